// file: tmsc_top.sv
`timescale 1ns/1ns
`include "tmsc_params.svh"

module tmsc_top (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output tmsc_pkg::tmsc_byte_t reg_rdata,
	input wire logic [2:0] count_preset_req,
	input wire logic [2:0] count_clear_req,
	input wire logic reg_c_capture,
	input wire logic reg_c_compare,
	input wire logic reg_a_capture,
	input wire logic reg_a_compare,
	output logic [2:0] count_preset,
	output logic [2:0] count_clear,
	output tmsc_pkg::tmsc_mode_t mode_ch0,
	output tmsc_pkg::tmsc_mode_t mode_ch1,
	output tmsc_pkg::tmsc_mode_t mode_ch2,
	output logic buffer_pair_enable,
	output logic reg_c_capture_evt,
	output logic reg_c_compare_evt,
	output logic buf_load_a_from_c,
	output logic buf_load_c_from_a,
	output logic [2:0] sync_enable
);
	import tmsc_pkg::*;

	// Mode decode is shared by the three channels; only channel 0 of this
	// group forbids phase counting, so the caller says whether it may.
	function automatic tmsc_mode_t decode_mode(input logic [3:0] md, input logic phase_ok);
		tmsc_mode_t m;
		m = TMSC_MODE_RESERVED;
		if (md[`TMSC_BIT_MODE_HI]) begin
			m = TMSC_MODE_RESERVED;
		end else if (md[`TMSC_BIT_MODE_PHASE]) begin
			if (!phase_ok) begin
				m = TMSC_MODE_RESERVED;
			end else begin
				unique case (md[1:0])
					2'h0: m = TMSC_MODE_PHASE1;
					2'h1: m = TMSC_MODE_PHASE2;
					2'h2: m = TMSC_MODE_PHASE3;
					2'h3: m = TMSC_MODE_PHASE4;
				endcase
			end
		end else begin
			unique case (md[1:0])
				2'h0: m = TMSC_MODE_NORMAL;
				2'h1: m = TMSC_MODE_RESERVED;
				2'h2: m = TMSC_MODE_PWM1;
				2'h3: m = TMSC_MODE_PWM2;
			endcase
		end
		return m;
	endfunction

	// A macro literal cannot be indexed, so the reset image is held as a constant.
	localparam tmsc_byte_t RST_MODE = `TMSC_RST_MODE;

	// Number of channels with their sync bit set.
	function automatic logic [1:0] count_ones(input logic [2:0] v);
		return {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
	endfunction

	logic rst_meta_reg;
	logic rst_n;

	logic buf_pair_reg;
	logic [3:0] mode0_reg;
	logic [3:0] mode1_reg;
	logic [3:0] mode2_reg;
	logic [2:0] sync_reg;
	logic [2:0] cclr0_reg;
	logic [2:0] cclr1_reg;
	logic [2:0] count_clear_source_2_reg;
	logic [2:0] last_preset_reg;
	logic [2:0] last_clear_reg;
	logic [7:0] rdata_next;
	logic wr_mode0;
	logic wr_mode1;
	logic wr_mode2;
	logic wr_sync;
	logic wr_cclr0;
	logic wr_cclr1;
	logic wr_count_clear_source_2;
	logic group_ok;
	logic group_preset;
	logic group_clear;
	logic rd_status;
	logic [2:0] clear_src [3];
	logic [2:0] preset_q;
	logic [2:0] clear_q;

	// Reset is asserted at once and released two clocks later.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	assign wr_mode0 = reg_wr && (reg_addr == `TMSC_OFS_MODE_CH0);
	assign wr_mode1 = reg_wr && (reg_addr == `TMSC_OFS_MODE_CH1);
	assign wr_mode2 = reg_wr && (reg_addr == `TMSC_OFS_MODE_CH2);
	assign wr_sync = reg_wr && (reg_addr == `TMSC_OFS_SYNC);
	assign wr_cclr0 = reg_wr && (reg_addr == `TMSC_OFS_CCLR_CH0);
	assign wr_cclr1 = reg_wr && (reg_addr == `TMSC_OFS_CCLR_CH1);
	assign wr_count_clear_source_2 = reg_wr && (reg_addr == `TMSC_OFS_CCLR_CH2);

	// Mode registers. Channels 1 and 2 have no buffer bit to store.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_pair_reg <= RST_MODE[`TMSC_BIT_BUF_PAIR];
			mode0_reg <= RST_MODE[3:0];
			mode1_reg <= RST_MODE[3:0];
			mode2_reg <= RST_MODE[3:0];
		end else begin
			if (wr_mode0) begin
				buf_pair_reg <= reg_wdata[`TMSC_BIT_BUF_PAIR];
				mode0_reg <= reg_wdata[3:0];
			end
			if (wr_mode1) begin
				mode1_reg <= reg_wdata[3:0];
			end
			if (wr_mode2) begin
				mode2_reg <= reg_wdata[3:0];
			end
		end
	end

	// Sync enables; the reserved upper bits are never stored.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg <= `TMSC_RST_SYNC;
		end else if (wr_sync) begin
			sync_reg <= reg_wdata[`TMSC_SYNC_MSB:0];
		end
	end

	// Counter clear source per channel.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cclr0_reg <= `TMSC_RST_CCLR;
			cclr1_reg <= `TMSC_RST_CCLR;
			count_clear_source_2_reg <= `TMSC_RST_CCLR;
		end else begin
			if (wr_cclr0) begin
				cclr0_reg <= reg_wdata[`TMSC_CCLR_MSB:0];
			end
			if (wr_cclr1) begin
				cclr1_reg <= reg_wdata[`TMSC_CCLR_MSB:0];
			end
			if (wr_count_clear_source_2) begin
				count_clear_source_2_reg <= reg_wdata[`TMSC_CCLR_MSB:0];
			end
		end
	end

	assign clear_src[0] = cclr0_reg;
	assign clear_src[1] = cclr1_reg;
	assign clear_src[2] = count_clear_source_2_reg;

	// A single synced channel has no partner, so the group acts only when
	// two or more channels are enabled; this keeps a lone bit harmless.
	assign group_ok = (count_ones(sync_reg) >= 2'd2);

	always_comb begin
		group_preset = group_ok && |(count_preset_req & sync_reg);
		group_clear = group_ok && |(count_clear_req & sync_reg);
	end

	for (genvar i = 0; i < `TMSC_NCH; i++) begin : g_chan
		tmsc_chan_sync u_sync (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.sync_en(sync_reg[i]),
			.clear_src(clear_src[i]),
			.own_preset(count_preset_req[i]),
			.own_clear(count_clear_req[i]),
			.group_preset(group_preset),
			.group_clear(group_clear),
			.preset_reg(preset_q[i]),
			.clear_reg(clear_q[i])
		);
	end

	assign count_preset = preset_q;
	assign count_clear = clear_q;

	// Status keeps every preset and clear output since the last read for software; hardware sets win
	// over the clear-on-read so no event is lost.
	assign rd_status = reg_rd && (reg_addr == `TMSC_OFS_STATUS);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_preset_reg <= 3'h0;
		end else if (rd_status) begin
			last_preset_reg <= preset_q;
		end else begin
			last_preset_reg <= last_preset_reg | preset_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_clear_reg <= 3'h0;
		end else if (rd_status) begin
			last_clear_reg <= clear_q;
		end else begin
			last_clear_reg <= last_clear_reg | clear_q;
		end
	end

	// Decoded modes and pairing, all registered.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ch0 <= TMSC_MODE_NORMAL;
			mode_ch1 <= TMSC_MODE_NORMAL;
			mode_ch2 <= TMSC_MODE_NORMAL;
			buffer_pair_enable <= 1'b0;
			sync_enable <= 3'h0;
		end else begin
			mode_ch0 <= decode_mode(mode0_reg, 1'b0);
			mode_ch1 <= decode_mode(mode1_reg, 1'b1);
			mode_ch2 <= decode_mode(mode2_reg, 1'b1);
			buffer_pair_enable <= buf_pair_reg;
			sync_enable <= sync_reg;
		end
	end

	// Register C events are swallowed while C buffers A. A compare match on A
	// reloads A from C; a capture on A pushes the old A value into C.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_c_capture_evt <= 1'b0;
			reg_c_compare_evt <= 1'b0;
		end else begin
			reg_c_capture_evt <= reg_c_capture & ~buf_pair_reg;
			reg_c_compare_evt <= reg_c_compare & ~buf_pair_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_load_a_from_c <= 1'b0;
			buf_load_c_from_a <= 1'b0;
		end else begin
			buf_load_a_from_c <= reg_a_compare & buf_pair_reg;
			buf_load_c_from_a <= reg_a_capture & buf_pair_reg;
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		rdata_next = 8'h00;
		unique case (reg_addr)
			`TMSC_OFS_MODE_CH0: rdata_next = {3'h0, buf_pair_reg, mode0_reg};
			`TMSC_OFS_MODE_CH1: rdata_next = {4'h0, mode1_reg};
			`TMSC_OFS_MODE_CH2: rdata_next = {4'h0, mode2_reg};
			`TMSC_OFS_SYNC: rdata_next = {5'h00, sync_reg};
			`TMSC_OFS_CCLR_CH0: rdata_next = {5'h00, cclr0_reg};
			`TMSC_OFS_CCLR_CH1: rdata_next = {5'h00, cclr1_reg};
			`TMSC_OFS_CCLR_CH2: rdata_next = {5'h00, count_clear_source_2_reg};
			`TMSC_OFS_STATUS: rdata_next = {1'b0, last_clear_reg, 1'b0, last_preset_reg};
			default: rdata_next = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// file: tmsc_params.svh
`ifndef TMSC_PARAMS_SVH
`define TMSC_PARAMS_SVH

// Register offsets on the plain register port.
`define TMSC_OFS_MODE_CH0 4'h0
`define TMSC_OFS_MODE_CH1 4'h1
`define TMSC_OFS_MODE_CH2 4'h2
`define TMSC_OFS_SYNC 4'h3
`define TMSC_OFS_CCLR_CH0 4'h4
`define TMSC_OFS_CCLR_CH1 4'h5
`define TMSC_OFS_CCLR_CH2 4'h6
`define TMSC_OFS_STATUS 4'h7

// Field positions.
`define TMSC_BIT_BUF_PAIR 4
`define TMSC_BIT_MODE_HI 3
`define TMSC_BIT_MODE_PHASE 2
`define TMSC_SYNC_MSB 2
`define TMSC_CCLR_MSB 2

// Reset values.
`define TMSC_RST_MODE 8'h00
`define TMSC_RST_SYNC 3'h0
`define TMSC_RST_CCLR 3'h0

// Clear source code that selects clearing by another synchronised channel.
`define TMSC_CCLR_SYNC 3'h3

// Number of channels served, the width of one register and the address width.
`define TMSC_NCH 3
`define TMSC_DW 8
`define TMSC_AW 4

`endif

// file: tmsc_pkg.sv
package tmsc_pkg;

	typedef enum logic [2:0] {
		TMSC_MODE_NORMAL,
		TMSC_MODE_PWM1,
		TMSC_MODE_PWM2,
		TMSC_MODE_PHASE1,
		TMSC_MODE_PHASE2,
		TMSC_MODE_PHASE3,
		TMSC_MODE_PHASE4,
		TMSC_MODE_RESERVED
	} tmsc_mode_t;

	typedef logic [7:0] tmsc_byte_t;

endpackage

// file: tmsc_chan_sync.sv
`timescale 1ns/1ns
`include "tmsc_params.svh"

// One channel's share of synchronous presetting and clearing.
module tmsc_chan_sync (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sync_en,
	input wire logic [2:0] clear_src,
	input wire logic own_preset,
	input wire logic own_clear,
	input wire logic group_preset,
	input wire logic group_clear,
	output logic preset_reg,
	output logic clear_reg
);
	import tmsc_pkg::*;

	logic preset_next;
	logic clear_next;

	always_comb begin
		// A channel outside the group sees only its own preset and clear.
		preset_next = own_preset | (sync_en & group_preset);
		clear_next = own_clear
			| (sync_en & (clear_src == `TMSC_CCLR_SYNC) & group_clear);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			preset_reg <= 1'b0;
			clear_reg <= 1'b0;
		end else begin
			preset_reg <= preset_next;
			clear_reg <= clear_next;
		end
	end

endmodule

// file: tmsc_top_asserts.sv
`timescale 1ns/1ns
module tmsc_top_asserts (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input tmsc_pkg::tmsc_byte_t reg_rdata,
	input wire logic [2:0] count_preset_req,
	input wire logic [2:0] count_clear_req,
	input wire logic reg_c_capture,
	input wire logic reg_c_compare,
	input wire logic reg_a_compare,
	input wire logic [2:0] count_preset,
	input wire logic [2:0] count_clear,
	input wire logic buffer_pair_enable,
	input wire logic reg_c_capture_evt,
	input wire logic reg_c_compare_evt,
	input wire logic buf_load_a_from_c,
	input wire logic [2:0] sync_enable
);
	import tmsc_pkg::*;
	// A lone sync bit forms no group, so a request then reaches only its own counter.
	function automatic logic [2:0] grp(input logic [2:0] r, input logic [2:0] s);
		grp = ((|(r & s)) && ($countones(s) > 1)) ? (r | s) : r;
	endfunction
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_c_cap; reg_c_capture |=> reg_c_capture_evt != buffer_pair_enable; endproperty
	a_c_cap: assert property (p_c_cap) else $error("C capture gating wrong");
	property p_c_cmp; reg_c_compare |=> reg_c_compare_evt != buffer_pair_enable; endproperty
	a_c_cmp: assert property (p_c_cmp) else $error("C compare gating wrong");
	property p_load; reg_a_compare |=> buf_load_a_from_c == buffer_pair_enable; endproperty
	a_load: assert property (p_load) else $error("buffer load wrong");
	// The copy on sync_enable lags the register by one cycle, as the strobes do.
	property p_preset; count_preset == grp($past(count_preset_req), sync_enable); endproperty
	a_preset: assert property (p_preset) else $error("preset spread wrong");
	property p_clr_own; (count_clear & $past(count_clear_req)) == $past(count_clear_req); endproperty
	a_clr_own: assert property (p_clr_own) else $error("own clear lost");
	property p_clr_grp; (count_clear & ~grp($past(count_clear_req), sync_enable)) == 3'h0; endproperty
	a_clr_grp: assert property (p_clr_grp) else $error("clear reached unsynced channel");
	property p_rd_sync; reg_rd && reg_addr == 4'h3 |=> reg_rdata[7:3] == 5'h00; endproperty
	a_rd_sync: assert property (p_rd_sync) else $error("sync upper bits set");
	property p_rd_bfa; reg_rd && reg_addr inside {4'h1, 4'h2} |=> !reg_rdata[4]; endproperty
	a_rd_bfa: assert property (p_rd_bfa) else $error("buffer bit seen on ch1 or ch2");
	c_grp_preset: cover property (count_preset == 3'h7);
	c_grp_clear: cover property (count_clear == 3'h3);
	c_load: cover property (buf_load_a_from_c);
endmodule

// file: tmsc_top_tb_top.sv
`timescale 1ns/1ns
module tmsc_top_tb_top;
	import tmsc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [2:0] count_preset_req = 3'h0;
	logic [2:0] count_clear_req = 3'h0;
	logic [3:0] ev = 4'h0;
	wire logic [3:0] ev_out;
	tmsc_byte_t reg_rdata;
	logic [2:0] count_preset;
	logic [2:0] count_clear;
	logic [2:0] sync_enable;
	logic buffer_pair_enable;
	tmsc_mode_t mode_ch0;
	tmsc_mode_t mode_ch1;
	tmsc_mode_t mode_ch2;
	int failures = 0;
	int comparisons = 0;
	tmsc_mode_t tbl [8] = '{TMSC_MODE_NORMAL, TMSC_MODE_RESERVED, TMSC_MODE_PWM1, TMSC_MODE_PWM2,
		TMSC_MODE_PHASE1, TMSC_MODE_PHASE2, TMSC_MODE_PHASE3, TMSC_MODE_PHASE4};
	always #25 ref_clk = ~ref_clk;
	tmsc_top u_dut (
		.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.count_preset_req, .count_clear_req, .count_preset, .count_clear,
		.reg_c_capture(ev[3]), .reg_c_compare(ev[2]), .reg_a_capture(ev[1]), .reg_a_compare(ev[0]),
		.reg_c_capture_evt(ev_out[3]), .reg_c_compare_evt(ev_out[2]),
		.buf_load_c_from_a(ev_out[1]), .buf_load_a_from_c(ev_out[0]),
		.mode_ch0, .mode_ch1, .mode_ch2, .buffer_pair_enable, .sync_enable
	);
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask
	task pulse(input logic [2:0] p, input logic [2:0] c, input logic [3:0] e);
		@(posedge ref_clk);
		count_preset_req <= p;
		count_clear_req <= c;
		ev <= e;
		@(posedge ref_clk);
		count_preset_req <= 3'h0;
		count_clear_req <= 3'h0;
		ev <= 4'h0;
		#1;
	endtask
	task sy(input logic [2:0] p, input logic [2:0] c, input logic [2:0] ep, input logic [2:0] ec);
		pulse(p, c, 4'h0);
		chk("count_preset", {5'h0, ep}, {5'h0, count_preset});
		chk("count_clear", {5'h0, ec}, {5'h0, count_clear});
	endtask
	task end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(4'h0, 8'h00);
		rd(4'h3, 8'h00);
		rd(4'h7, 8'h00);
		chk("sync_enable", 8'h00, {5'h0, sync_enable});
		$display("test reset done");
		// Bit 4 is written on channel 1 every time and must never stick.
		for (int i = 0; i < 8; i++) begin
			wr(4'h1, 8'h10 | 8'(i));
			rd(4'h1, 8'(i));
			chk("mode_ch1", {5'h0, tbl[i]}, {5'h0, mode_ch1});
		end
		wr(4'h2, 8'h12);
		rd(4'h2, 8'h02);
		chk("mode_ch2", {5'h0, TMSC_MODE_PWM1}, {5'h0, mode_ch2});
		$display("test modes done");
		wr(4'h0, 8'h13);
		rd(4'h0, 8'h13);
		chk("mode_ch0", {5'h0, TMSC_MODE_PWM2}, {5'h0, mode_ch0});
		chk("buffer_pair_enable", 8'h01, {7'h0, buffer_pair_enable});
		pulse(3'h0, 3'h0, 4'hf);
		chk("events paired", 8'h03, {4'h0, ev_out});
		wr(4'h0, 8'h02);
		rd(4'h0, 8'h02);
		pulse(3'h0, 3'h0, 4'hf);
		chk("events single", 8'h0c, {4'h0, ev_out});
		$display("test buffer done");
		wr(4'h3, 8'h03);
		wr(4'h4, 8'h03);
		wr(4'h5, 8'h03);
		wr(4'h6, 8'h03);
		rd(4'h3, 8'h03);
		rd(4'h4, 8'h03);
		chk("sync_enable", 8'h03, {5'h0, sync_enable});
		sy(3'h1, 3'h0, 3'h3, 3'h0);
		sy(3'h4, 3'h0, 3'h4, 3'h0);
		sy(3'h0, 3'h1, 3'h0, 3'h3);
		sy(3'h0, 3'h4, 3'h0, 3'h4);
		wr(4'h3, 8'h07);
		wr(4'h6, 8'h00);
		rd(4'h6, 8'h00);
		sy(3'h2, 3'h2, 3'h7, 3'h3);
		wr(4'h3, 8'h01);
		sy(3'h1, 3'h1, 3'h1, 3'h1);
		sy(3'h2, 3'h0, 3'h2, 3'h0);
		rd(4'h8, 8'h00);
		rd(4'hf, 8'h00);
		rd(4'h7, 8'h77);
		rd(4'h7, 8'h00);
		$display("test sync done");
		end_sim;
	end
endmodule
bind tmsc_top tmsc_top_asserts u_chk (
	.ref_clk, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .count_preset_req, .count_clear_req,
	.reg_c_capture, .reg_c_compare, .reg_a_compare, .count_preset, .count_clear,
	.buffer_pair_enable, .reg_c_capture_evt, .reg_c_compare_evt, .buf_load_a_from_c, .sync_enable
);
